// >>> hw/ccc_conv_ctrl.sv
// Command decode and conversion sequencing for a ten channel
// temperature converter. Assumes one clock and a host that uses the
// plain byte port below; the analog front end answers on the same clock.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ccc_conv_ctrl #(
    parameter int CYCLE_CLKS = ccc_pkg::MEAS_CYCLE_CLKS,
    parameter bit HAS_NVM = 1'b0
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [9:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic conv_int,
    output logic irq,
    output logic sleeping,
    output logic meas_start,
    output logic [4:0] meas_channel,
    output logic [4:0] meas_assoc,
    output logic [4:0] meas_kind,
    input wire logic [31:0] meas_result,
    output logic nvm_req,
    output logic nvm_write,
    input wire logic nvm_ack
);
    localparam int TW = $clog2(CYCLE_CLKS + 1);
    localparam logic [TW-1:0] TIMER_LOAD = TW'(CYCLE_CLKS - 1);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic ccc_pkg::ccc_kind_e kind_of(input logic [4:0] code);
        if (code == 5'h00) return ccc_pkg::KIND_NONE;
        else if (code <= ccc_pkg::TC_HI) return ccc_pkg::KIND_TC;
        else if (code <= ccc_pkg::RTD_HI) return ccc_pkg::KIND_RTD;
        else if (code <= ccc_pkg::TH_HI) return ccc_pkg::KIND_THERM;
        else if (code == ccc_pkg::DIODE_CODE) return ccc_pkg::KIND_DIODE;
        else if (code == ccc_pkg::SENSE_CODE) return ccc_pkg::KIND_SENSE;
        else if (code == ccc_pkg::ADC_CODE) return ccc_pkg::KIND_ADC;
        else if (code == ccc_pkg::ANALOG_CODE) return ccc_pkg::KIND_ANALOG;
        else return ccc_pkg::KIND_RSVD;
    endfunction : kind_of

    // Byte 0 of a word is its top byte, so fault flags read first
    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] b);
        case (b)
            2'h0: return w[31:24];
            2'h1: return w[23:16];
            2'h2: return w[15:8];
            default: return w[7:0];
        endcase
    endfunction : byte_of

    // ----------------------------------------
    // State
    // ----------------------------------------
    ccc_pkg::ccc_state_e state;
    logic [7:0] status;
    logic [4:0] chan;
    logic multi;
    logic [1:0] cyc_left;
    logic [TW-1:0] timer;
    logic [31:0] assign_mem [ccc_pkg::NUM_CH];
    logic [31:0] result_mem [ccc_pkg::NUM_CH];
    logic [ccc_pkg::IRQ_W-1:0] irq_stat;
    logic [ccc_pkg::IRQ_W-1:0] irq_mask;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire logic busy = (state != ccc_pkg::ST_IDLE) && (state != ccc_pkg::ST_SLEEP);
    wire logic at_cmd = bus_addr == ccc_pkg::CMD_STATUS_ADDR;
    wire logic at_istat = bus_addr == ccc_pkg::IRQ_STATUS_ADDR;
    wire logic at_imask = bus_addr == ccc_pkg::IRQ_MASK_ADDR;
    wire logic in_res = bus_addr >= ccc_pkg::RESULT_BASE && bus_addr <= ccc_pkg::RESULT_END;
    wire logic in_asg = bus_addr >= ccc_pkg::ASSIGN_BASE && bus_addr <= ccc_pkg::ASSIGN_END;
    wire logic [9:0] res_off = bus_addr - ccc_pkg::RESULT_BASE;
    wire logic [9:0] asg_off = bus_addr - ccc_pkg::ASSIGN_BASE;
    wire logic [3:0] res_idx = res_off[5:2];
    wire logic [3:0] asg_idx = asg_off[5:2];
    // Interrupt registers are not part of the RAM, so the lockout spares them
    wire logic ram_acc = !at_istat && !at_imask;
    wire logic locked = busy && ram_acc && !at_cmd;
    wire logic refused = busy && ram_acc && (bus_wr || (bus_rd && !at_cmd));

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    wire logic cmd_wr = bus_wr && at_cmd && !busy;
    wire logic [4:0] sel = bus_wdata[4:0];
    // A set spare bit makes the byte reserved
    wire logic start_top = bus_wdata[7:5] == ccc_pkg::START_TOP;
    wire logic is_sleep = bus_wdata == ccc_pkg::SLEEP_CMD;
    wire logic is_multi = start_top && sel == ccc_pkg::CH_MULTI;
    wire logic is_single = start_top && sel >= ccc_pkg::CH_FIRST && sel <= ccc_pkg::CH_LAST;
    wire logic is_nvm = HAS_NVM && start_top
        && (sel == ccc_pkg::NVM_READ_SEL || sel == ccc_pkg::NVM_WRITE_SEL);
    wire logic is_rsvd = cmd_wr && !is_sleep && !is_multi && !is_single && !is_nvm;

    // ----------------------------------------
    // Channel under measurement
    // ----------------------------------------
    wire logic [4:0] chm1 = chan - 5'h01;
    wire logic chan_ok = chan >= ccc_pkg::CH_FIRST && chan <= ccc_pkg::CH_LAST;
    wire logic [31:0] cur_word = chan_ok ? assign_mem[chm1[3:0]] : 32'h0000_0000;
    wire logic [4:0] cur_code = cur_word[ccc_pkg::TYPE_LSB +: 5];
    wire ccc_pkg::ccc_kind_e cur_kind = kind_of(cur_code);
    // Sensors with a sense resistor need the extra cycle
    wire logic three_cyc = cur_kind == ccc_pkg::KIND_RTD || cur_kind == ccc_pkg::KIND_THERM;
    wire logic [1:0] ncyc = three_cyc ? ccc_pkg::CYCLES_LONG : ccc_pkg::CYCLES_SHORT;
    wire logic pair_kind = cur_kind == ccc_pkg::KIND_TC || three_cyc;
    wire logic [4:0] assoc = pair_kind ? cur_word[ccc_pkg::ASSOC_LSB +: 5] : 5'h00;
    wire logic timer_end = timer == '0;
    wire logic capture = state == ccc_pkg::ST_MEAS && timer_end && cyc_left == 2'h0;
    wire logic scan_over = chan > ccc_pkg::CH_LAST;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= ccc_pkg::ST_IDLE;
            chan <= 5'h00;
            multi <= 1'b0;
            cyc_left <= 2'h0;
            timer <= '0;
            sleeping <= 1'b0;
            nvm_req <= 1'b0;
            nvm_write <= 1'b0;
        end else begin
            case (state)
                ccc_pkg::ST_IDLE, ccc_pkg::ST_SLEEP: begin
                    if (cmd_wr && !is_rsvd) begin
                        sleeping <= is_sleep;
                        chan <= is_multi ? ccc_pkg::CH_FIRST : sel;
                        multi <= is_multi;
                        nvm_req <= is_nvm;
                        nvm_write <= sel == ccc_pkg::NVM_WRITE_SEL;
                        if (is_sleep) state <= ccc_pkg::ST_SLEEP;
                        else if (is_nvm) state <= ccc_pkg::ST_NVM;
                        else if (is_multi) state <= ccc_pkg::ST_PICK;
                        else state <= ccc_pkg::ST_LOAD;
                    end
                end
                ccc_pkg::ST_PICK: begin
                    // Unassigned channels are skipped during a scan
                    if (scan_over) state <= ccc_pkg::ST_FINISH;
                    else if (cur_kind == ccc_pkg::KIND_NONE) chan <= chan + 5'h01;
                    else state <= ccc_pkg::ST_LOAD;
                end
                ccc_pkg::ST_LOAD: begin
                    cyc_left <= ncyc - 2'h1;
                    timer <= TIMER_LOAD;
                    state <= ccc_pkg::ST_MEAS;
                end
                ccc_pkg::ST_MEAS: begin
                    timer <= timer_end ? TIMER_LOAD : timer - TW'(1);
                    if (timer_end && cyc_left != 2'h0) cyc_left <= cyc_left - 2'h1;
                    if (capture) begin
                        chan <= chan + 5'h01;
                        state <= multi ? ccc_pkg::ST_PICK : ccc_pkg::ST_FINISH;
                    end
                end
                ccc_pkg::ST_NVM: begin
                    if (nvm_ack) begin
                        nvm_req <= 1'b0;
                        state <= ccc_pkg::ST_FINISH;
                    end
                end
                ccc_pkg::ST_FINISH: state <= ccc_pkg::ST_IDLE;
                default: state <= ccc_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Front end strobes
    // ----------------------------------------
    wire logic next_meas_start = state == ccc_pkg::ST_LOAD
        || (state == ccc_pkg::ST_MEAS && timer_end && cyc_left != 2'h0);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meas_start <= 1'b0;
            meas_channel <= 5'h00;
            meas_assoc <= 5'h00;
            meas_kind <= 5'h00;
        end else begin
            meas_start <= next_meas_start;
            if (state == ccc_pkg::ST_LOAD) begin
                meas_channel <= chan;
                meas_assoc <= assoc;
                meas_kind <= cur_code;
            end
        end
    end

    // ----------------------------------------
    // Status byte and interrupt pin
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status <= ccc_pkg::STATUS_RESET;
            conv_int <= 1'b1;
        end else if (state == ccc_pkg::ST_FINISH) begin
            status[ccc_pkg::GO_POS -: 2] <= ccc_pkg::DONE_FLAGS;
            conv_int <= 1'b1;
        end else if (cmd_wr && !is_rsvd) begin
            status <= bus_wdata;
            conv_int <= is_sleep;
        end
    end

    // ----------------------------------------
    // Assignment and result storage
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < ccc_pkg::NUM_CH; i++) begin
                assign_mem[i] <= 32'h0000_0000;
                result_mem[i] <= 32'h0000_0000;
            end
        end else begin
            if (bus_wr && in_asg && !busy) begin
                case (asg_off[1:0])
                    2'h0: assign_mem[asg_idx][31:24] <= bus_wdata;
                    2'h1: assign_mem[asg_idx][23:16] <= bus_wdata;
                    2'h2: assign_mem[asg_idx][15:8] <= bus_wdata;
                    default: assign_mem[asg_idx][7:0] <= bus_wdata;
                endcase
            end
            if (capture) result_mem[chm1[3:0]] <= meas_result;
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    wire logic [ccc_pkg::IRQ_W-1:0] irq_set = {refused, is_rsvd, state == ccc_pkg::ST_FINISH};
    wire logic [ccc_pkg::IRQ_W-1:0] irq_clr = (bus_wr && at_istat) ? bus_wdata[ccc_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end else begin
            // A new event beats a clear in the same cycle
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            if (bus_wr && at_imask) irq_mask <= bus_wdata[ccc_pkg::IRQ_W-1:0];
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    wire logic [7:0] rd_val =
        at_cmd ? status :
        locked ? 8'h00 :
        in_res ? byte_of(result_mem[res_idx], res_off[1:0]) :
        in_asg ? byte_of(assign_mem[asg_idx], asg_off[1:0]) :
        at_istat ? {5'h00, irq_stat} :
        at_imask ? {5'h00, irq_mask} : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (reset) bus_rdata <= 8'h00;
        else bus_rdata <= bus_rd ? rd_val : 8'h00;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    logic [1:0] starts_seen;
    logic [1:0] cyc_want;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            starts_seen <= 2'h0;
            cyc_want <= 2'h0;
        end else if (state == ccc_pkg::ST_LOAD) begin
            starts_seen <= 2'h0;
            cyc_want <= ncyc;
        end else if (meas_start) begin
            starts_seen <= starts_seen + 2'h1;
        end
    end

    sequence s_start_cmd;
        cmd_wr && (is_multi || is_single);
    endsequence
    sequence s_single_go;
        cmd_wr && is_single ##1 state == ccc_pkg::ST_LOAD;
    endsequence

    a_start_pin_low: assert property (s_start_cmd |=> !conv_int)
        else $error("interrupt pin not low after start");
    a_pin_low_meas: assert property (state == ccc_pkg::ST_MEAS |-> !conv_int)
        else $error("interrupt pin high during measurement");
    a_done_flags: assert property (state == ccc_pkg::ST_FINISH |=> status[7:6] == 2'b01 && conv_int)
        else $error("completion flags or pin wrong");
    a_locked_read: assert property (busy && bus_rd && !at_cmd && ram_acc |=> bus_rdata == 8'h00)
        else $error("locked read returned data");
    a_locked_write: assert property (busy && bus_wr && bus_addr == ccc_pkg::ASSIGN_BASE
        |=> $stable(assign_mem[0]))
        else $error("assignment written while busy");
    a_multi_scan: assert property (cmd_wr && is_multi |=> state == ccc_pkg::ST_PICK && chan == 5'h01)
        else $error("scan did not start at first channel");
    a_single_chan: assert property (s_single_go |=> meas_start && meas_channel == $past(bus_wdata[4:0], 2))
        else $error("wrong channel measured");
    a_sleep_entry: assert property (cmd_wr && is_sleep |=> sleeping && state == ccc_pkg::ST_SLEEP && conv_int)
        else $error("sleep command not honoured");
    a_reserved_noop: assert property (is_rsvd |=> status == $past(status) && !busy)
        else $error("reserved command had an effect");
    a_go_while_busy: assert property (state == ccc_pkg::ST_MEAS |-> status[7:6] == 2'b10)
        else $error("status not go during conversion");
    a_cycle_count: assert property (capture |-> starts_seen == cyc_want)
        else $error("wrong number of measurement cycles");
endmodule : ccc_conv_ctrl
`default_nettype wire

// >>> include/ccc_pkg.sv
// Constants shared by the conversion command and sequencing logic.
// Assumes an 8-bit RAM-style host port with a 10-bit byte address.
package ccc_pkg;
    // ----------------------------------------
    // Address map
    // ----------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [9:0] CMD_STATUS_ADDR = 10'h000;
    localparam logic [9:0] RESULT_BASE = 10'h010;
    localparam logic [9:0] RESULT_END = 10'h037;
    localparam logic [9:0] ASSIGN_BASE = 10'h200;
    localparam logic [9:0] ASSIGN_END = 10'h227;
    localparam logic [9:0] IRQ_STATUS_ADDR = 10'h3f0;
    localparam logic [9:0] IRQ_MASK_ADDR = 10'h3f4;

    // ----------------------------------------
    // Command and status byte
    // ----------------------------------------
    localparam int GO_POS = 7;
    localparam int FIN_POS = 6;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [2:0] START_TOP = 3'h4;
    localparam logic [1:0] DONE_FLAGS = 2'h1;
    localparam logic [7:0] SLEEP_CMD = 8'h97;
    localparam logic [4:0] CH_MULTI = 5'h00;
    localparam logic [4:0] CH_FIRST = 5'h01;
    localparam logic [4:0] CH_LAST = 5'h0a;
    localparam logic [4:0] NVM_READ_SEL = 5'h15;
    localparam logic [4:0] NVM_WRITE_SEL = 5'h16;
    localparam int NUM_CH = 10;

    // ----------------------------------------
    // Channel assignment word
    // ----------------------------------------
    localparam int TYPE_LSB = 27;
    localparam int ASSOC_LSB = 22;
    localparam logic [4:0] TC_LO = 5'h01;
    localparam logic [4:0] TC_HI = 5'h09;
    localparam logic [4:0] RTD_LO = 5'h0a;
    localparam logic [4:0] RTD_HI = 5'h12;
    localparam logic [4:0] TH_LO = 5'h13;
    localparam logic [4:0] TH_HI = 5'h19;
    localparam logic [4:0] DIODE_CODE = 5'h1c;
    localparam logic [4:0] SENSE_CODE = 5'h1d;
    localparam logic [4:0] ADC_CODE = 5'h1e;
    localparam logic [4:0] ANALOG_CODE = 5'h1f;

    // ----------------------------------------
    // Interrupt status bits
    // ----------------------------------------
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_RSVD = 1;
    localparam int IRQ_LOCK = 2;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int MEAS_CYCLE_NS = 82_000_000;
    localparam int MEAS_CYCLE_CLKS = MEAS_CYCLE_NS / CLK_PERIOD_NS;
    localparam logic [1:0] CYCLES_SHORT = 2'h2;
    localparam logic [1:0] CYCLES_LONG = 2'h3;

    typedef enum logic [3:0] {
        KIND_NONE, KIND_TC, KIND_RTD, KIND_THERM, KIND_DIODE,
        KIND_SENSE, KIND_ADC, KIND_ANALOG, KIND_RSVD
    } ccc_kind_e;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SLEEP, ST_PICK, ST_LOAD, ST_MEAS, ST_FINISH, ST_NVM
    } ccc_state_e;
endpackage : ccc_pkg

// >>> tb/ccc_front_model.sv
// Behavioural model of the analog front end that answers each measurement.
// Assumes meas_start pulses once per measurement cycle of CYCLE_CLKS clocks.
`timescale 1ns/1ps
`default_nettype none
module ccc_front_model #(
    parameter int CYCLE_CLKS = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic meas_start,
    input wire logic [4:0] meas_channel,
    input wire logic [4:0] meas_assoc,
    output logic [31:0] meas_result
);
    int hold;

    // ----------------------------------------
    // Result word
    // ----------------------------------------
    // Sensor and its associated channel are captured together; outside a
    // measurement the value churns so a late sample cannot pass by luck
    always @(posedge ref_clk) begin
        if (reset) begin
            meas_result <= 32'h5a5a5a5a;
            hold <= 0;
        end else if (meas_start) begin
            meas_result <= {8'h01, 3'h0, meas_assoc, 11'h000, meas_channel};
            hold <= CYCLE_CLKS;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else begin
            meas_result <= ~meas_result;
        end
    end
endmodule : ccc_front_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the conversion command and sequencing block.
// Assumes a short CYCLE_CLKS and the front end model on the result input.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int CYC = 8;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [9:0] bus_addr = 10'h000;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic conv_int, irq, sleeping, meas_start, nvm_req, nvm_write;
    logic [4:0] meas_channel, meas_assoc, meas_kind, seen_ch, seen_kind, seen_assoc;
    logic [31:0] meas_result, w, exp_res;
    logic [31:0] words [1:10];
    logic [7:0] d, b;
    int error_cnt = 0;
    int check_count = 0;
    int starts, ts, t, e, ac;
    logic nvm_ack = 1'b0;
    logic nvm_pin, nvm_busy, nvm_dir;

    ccc_conv_ctrl #(.CYCLE_CLKS(CYC), .HAS_NVM(1'b0)) uut (.ref_clk(ref_clk), .reset(reset),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .conv_int(conv_int), .irq(irq), .sleeping(sleeping),
        .meas_start(meas_start), .meas_channel(meas_channel), .meas_assoc(meas_assoc),
        .meas_kind(meas_kind), .meas_result(meas_result), .nvm_req(nvm_req),
        .nvm_write(nvm_write), .nvm_ack(nvm_ack));
    // Twin with the nonvolatile decode on, fed the same bus, for the memory commands
    ccc_conv_ctrl #(.CYCLE_CLKS(CYC), .HAS_NVM(1'b1)) uut_nvm (.ref_clk(ref_clk), .reset(reset),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(),
        .conv_int(nvm_pin), .irq(), .sleeping(), .meas_start(), .meas_channel(), .meas_assoc(),
        .meas_kind(), .meas_result(meas_result), .nvm_req(nvm_busy), .nvm_write(nvm_dir),
        .nvm_ack(nvm_ack));
    ccc_front_model #(.CYCLE_CLKS(CYC)) fe (.ref_clk(ref_clk), .reset(reset), .meas_start(meas_start),
        .meas_channel(meas_channel), .meas_assoc(meas_assoc), .meas_result(meas_result));

    initial forever #2 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (meas_start === 1'b1) begin
            starts <= starts + 1;
            seen_ch <= meas_channel;
            seen_kind <= meas_kind;
            seen_assoc <= meas_assoc;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic int n_of(input logic [4:0] k);
        return (k >= 5'h0a && k <= 5'h19) ? 3 : 2;
    endfunction : n_of
    function automatic logic [4:0] assoc_of(input logic [31:0] x);
        return (x[31:27] >= 5'h01 && x[31:27] <= 5'h19) ? x[26:22] : 5'h00;
    endfunction : assoc_of
    function automatic bit legal(input logic [7:0] c);
        return c[7:5] == 3'h4 && (c[4:0] <= 5'h0a || c[4:0] == 5'h17);
    endfunction : legal
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        check_count++;
        if (seen !== expv) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask : rd
    task automatic clear_irq();
        wr(ccc_pkg::IRQ_STATUS_ADDR, 8'h07);
        repeat (2) @(posedge ref_clk);
        #1 chk(irq, 1'b0);
    endtask : clear_irq
    // Busy-time probes ride along with every conversion
    // Overhead: load and finish for one channel; a scan has the finish plus a pick per channel,
    // an end pick and a load per assigned channel
    task automatic conv(input logic [7:0] cmd, input int n, input int ovh);
        starts = 0;
        wr(ccc_pkg::CMD_STATUS_ADDR, cmd);
        #1 ts = $time;
        chk(conv_int, 1'b0);
        rd(ccc_pkg::CMD_STATUS_ADDR);
        chk(d, cmd);
        rd(ccc_pkg::RESULT_BASE);
        chk(d, 8'h00);
        wr(ccc_pkg::ASSIGN_BASE, 8'hff);
        t = 0;
        while (conv_int !== 1'b1 && t < 2000) begin
            @(posedge ref_clk);
            #1 t++;
            if (conv_int !== 1'b1) chk({conv_int, irq}, 2'h0);
        end
        chk(starts, n);
        t = ($time - ts) / 4;
        chk(t, n * CYC + ovh);
        rd(ccc_pkg::CMD_STATUS_ADDR);
        chk(d[7:6], 2'h1);
        chk(irq, 1'b1);
    endtask : conv

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        results();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h6bf84877));
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1 chk({conv_int, irq, sleeping}, 3'h4);
        rd(ccc_pkg::CMD_STATUS_ADDR);
        chk(d, ccc_pkg::STATUS_RESET);
        for (int a = 0; a < 40; a++) begin
            rd(ccc_pkg::ASSIGN_BASE + 10'(a));
            chk(d, 8'h00);
        end
        rd(10'h300);
        chk(d, 8'h00);
        $display("test reset values done");
        wr(ccc_pkg::IRQ_MASK_ADDR, 8'h01);
        // Four rounds walk every sensor code through the channels
        for (int r = 0; r < 4; r++) begin
            e = 0;
            ac = 0;
            for (int n = 1; n <= 10; n++) begin
                w = {5'((r * 10 + n - 1) % 32), 27'($urandom)};
                words[n] = w;
                if (w[31:27] != 5'h00) begin
                    e += n_of(w[31:27]);
                    ac++;
                end
                for (int k = 0; k < 4; k++) wr(ccc_pkg::ASSIGN_BASE + 10'(4 * (n - 1) + k), w[31 - 8 * k -: 8]);
            end
            for (int n = 1; n <= 10; n++) begin
                conv(8'h80 | 8'(n), n_of(words[n][31:27]), 2);
                chk(seen_ch, 5'(n));
                chk(seen_kind, words[n][31:27]);
                chk(seen_assoc, assoc_of(words[n]));
                exp_res = {8'h01, 3'h0, assoc_of(words[n]), 11'h000, 5'(n)};
                for (int k = 0; k < 4; k++) begin
                    rd(ccc_pkg::RESULT_BASE + 10'(4 * (n - 1) + k));
                    chk(d, exp_res[31 - 8 * k -: 8]);
                end
                rd(ccc_pkg::ASSIGN_BASE);
                chk(d, words[1][31:24]);
                clear_irq();
            end
            conv(8'h80, e, 12 + ac);
            clear_irq();
            $display("test round %0d done", r);
        end
        wr(ccc_pkg::CMD_STATUS_ADDR, ccc_pkg::SLEEP_CMD);
        #1 chk({sleeping, conv_int}, 2'h3);
        conv(8'h81, n_of(words[1][31:27]), 2);
        chk(sleeping, 1'b0);
        clear_irq();
        $display("test sleep done");
        wr(ccc_pkg::IRQ_MASK_ADDR, 8'h02);
        for (int i = 0; i < 10; i++) begin
            b = (i == 0) ? 8'h8b : (i == 1) ? 8'ha1 : (i == 2) ? 8'hc1 : (i == 3) ? 8'h95 : 8'($urandom);
            while (legal(b)) b = 8'($urandom);
            rd(ccc_pkg::CMD_STATUS_ADDR);
            w = {24'h0, d};
            wr(ccc_pkg::CMD_STATUS_ADDR, b);
            #1 chk(conv_int, 1'b1);
            rd(ccc_pkg::CMD_STATUS_ADDR);
            chk(d, w[7:0]);
            chk(irq, 1'b1);
            chk({nvm_req, nvm_write}, 2'h0);
            if (i == 3) begin
                chk({nvm_busy, nvm_dir, nvm_pin}, 3'h4);
                @(posedge ref_clk);
                nvm_ack <= 1'b1;
                @(posedge ref_clk);
                nvm_ack <= 1'b0;
                repeat (2) @(posedge ref_clk);
                #1 chk({nvm_busy, nvm_pin}, 2'h1);
            end
            clear_irq();
        end
        $display("test reserved commands done");
        results();
    end
endmodule : tb
`default_nettype wire
